/* File: src/mca_pkg.sv */
package mca_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] MCA_OFS_CONFIG = 8'h00;
   localparam logic [7:0] MCA_OFS_STATUS = 8'h01;
   localparam logic [7:0] MCA_OFS_MASK   = 8'h03;
   localparam logic [7:0] MCA_OFS_ADVCFG = 8'h0B;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] MCA_RST_CONFIG = 8'h08;
   localparam logic [7:0] MCA_RST_STATUS = 8'h00;
   localparam logic [7:0] MCA_RST_MASK   = 8'h00;
   localparam logic [7:0] MCA_RST_ADVCFG = 8'h00;

   // ---------------------------------------------------------------
   // configuration fields
   // ---------------------------------------------------------------
   localparam int         MCA_CFG_START  = 0;
   localparam int         MCA_CFG_OUT_EN = 1;
   localparam int         MCA_CFG_CLEAR  = 3;
   localparam int         MCA_CFG_INIT   = 7;
   localparam logic [7:0] MCA_CFG_WMASK  = 8'h8B;

   // ---------------------------------------------------------------
   // advanced configuration: mode field bits 2:1
   // ---------------------------------------------------------------
   localparam int         MCA_ADV_MODE_LO = 1;
   localparam logic [7:0] MCA_ADV_WMASK   = 8'h07;

   typedef enum logic [1:0]
   {
      MCA_MODE_0 = 2'h0,
      MCA_MODE_1 = 2'h1,
      MCA_MODE_2 = 2'h2,
      MCA_MODE_3 = 2'h3
   } mca_mode_t;

endpackage

/* File: src/mca_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module mca_regs
   import mca_pkg::*;
#(
   // sizes the register map is laid out for
   parameter int REG_W = 8,
   parameter int SLOTS = 8
)
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // register port from the serial engine
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   // comparator flags from the sequencer
   input  wire logic [7:0] over_high,
   input  wire logic [7:0] under_low,
   input  wire logic       temp_high,
   input  wire logic       flags_valid,
   // controls to the sequencer
   output logic            run,
   output logic            scan_hold,
   output logic            restore_pulse,
   output logic [1:0]      mode,
   // alarm pin
   output logic            alarm_n
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [7:0] config_reg;
   logic [7:0] status_reg;
   logic [7:0] mask_reg;
   logic [7:0] advcfg_reg;
   logic       restore_reg;
   logic [7:0] events;
   logic       alarm_n_reg;
   logic       alarm_n_next;
   mca_mode_t  mode_cur;
   logic       cfg_we;
   logic       mask_we;
   logic       adv_we;
   logic       status_take;
   logic       alarm_cause;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = reg_wr && (a == ofs);
   endfunction

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   // ports, mode table and read mux are byte wide, eight slots
   if (REG_W != 8 || SLOTS != 8)
   begin : g_size_check
      $error("mca_regs: only byte registers with eight slots are supported");
   end

   // a reserved bit in the reset value would read back but could never be written again
   if ((MCA_RST_CONFIG & ~MCA_CFG_WMASK) != 8'h00)
   begin : g_reset_check
      $error("mca_regs: config reset value sets a reserved bit");
   end

   // mode field must be writable or the mode table is out of reach
   if (MCA_ADV_WMASK[MCA_ADV_MODE_LO +: 2] != 2'h3)
   begin : g_mode_check
      $error("mca_regs: mode field not writable");
   end

   // ---------------------------------------------------------------
   // write decode
   // ---------------------------------------------------------------
   // status and unmapped offsets decode to nothing
   assign cfg_we  = hit(reg_addr, MCA_OFS_CONFIG);
   assign mask_we = hit(reg_addr, MCA_OFS_MASK);
   assign adv_we  = hit(reg_addr, MCA_OFS_ADVCFG);

   // ---------------------------------------------------------------
   // restore-defaults: one cycle pulse, bit drops after
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         restore_reg <= 1'b0;
      else
         restore_reg <= cfg_we && reg_wdata[MCA_CFG_INIT];
   end

   assign restore_pulse = restore_reg;

   // ---------------------------------------------------------------
   // configuration
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         config_reg <= MCA_RST_CONFIG;
      else if (restore_reg)
         config_reg <= MCA_RST_CONFIG;
      else if (cfg_we)
         config_reg <= reg_wdata & MCA_CFG_WMASK;
   end

   // ---------------------------------------------------------------
   // mask and advanced configuration
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         mask_reg <= MCA_RST_MASK;
      else if (restore_reg)
         mask_reg <= MCA_RST_MASK;
      else if (mask_we)
         mask_reg <= reg_wdata;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         advcfg_reg <= MCA_RST_ADVCFG;
      else if (restore_reg)
         advcfg_reg <= MCA_RST_ADVCFG;
      else if (adv_we)
         advcfg_reg <= reg_wdata & MCA_ADV_WMASK;
   end

   assign mode_cur = mca_mode_t'(advcfg_reg[MCA_ADV_MODE_LO +: 2]);
   assign mode     = mode_cur;

   // ---------------------------------------------------------------
   // status: sticky, read-only
   // ---------------------------------------------------------------
   mca_status_map u_map
   (
      .mode      (mode_cur),
      .over_high (over_high),
      .under_low (under_low),
      .temp_high (temp_high),
      .events    (events)
   );

   // events seen while shut down are dropped, not held for later
   assign status_take = flags_valid && config_reg[MCA_CFG_START];

   // restore wins: it is the only way to clear, and a stale flag would survive it
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         status_reg <= MCA_RST_STATUS;
      else if (restore_reg)
         status_reg <= MCA_RST_STATUS;
      else if (status_take)
         status_reg <= status_reg | events;
   end

   // ---------------------------------------------------------------
   // alarm pin, registered to avoid glitches
   // ---------------------------------------------------------------
   // a mode change keeps old bits, so the pin still sees them
   assign alarm_cause  = |(status_reg & ~mask_reg);
   assign alarm_n_next = ~(config_reg[MCA_CFG_OUT_EN] && !config_reg[MCA_CFG_CLEAR]
                           && alarm_cause);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         alarm_n_reg <= 1'b1;
      else
         alarm_n_reg <= alarm_n_next;
   end

   assign alarm_n = alarm_n_reg;

   // ---------------------------------------------------------------
   // sequencer controls
   // ---------------------------------------------------------------
   assign run       = config_reg[MCA_CFG_START];
   // hold only pauses the scan; a strobe already in flight still lands
   assign scan_hold = config_reg[MCA_CFG_CLEAR];

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else
         case (reg_addr)
            MCA_OFS_CONFIG: reg_rdata <= config_reg;
            MCA_OFS_STATUS: reg_rdata <= status_reg;
            MCA_OFS_MASK:   reg_rdata <= mask_reg;
            MCA_OFS_ADVCFG: reg_rdata <= advcfg_reg;
            default:        reg_rdata <= 8'h00;
         endcase
   end

endmodule // mca_regs
`default_nettype wire

/* File: src/mca_status_map.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// maps per-channel limit flags to status bits by mode
// ---------------------------------------------------------------
module mca_status_map
   import mca_pkg::*;
(
   // mode and flags
   input  wire mca_mode_t  mode,
   input  wire logic [7:0] over_high,
   input  wire logic [7:0] under_low,
   input  wire logic       temp_high,
   // mapped events
   output logic [7:0]      events
);

   logic [7:0] out_of_range;

   assign out_of_range = over_high | under_low;

   // slot k of the flags carries the k-th measurement of the mode
   always_comb
   begin
      events = 8'h00;
      case (mode)
         MCA_MODE_0:
         begin
            events = {temp_high, out_of_range[6:0]};
         end
         MCA_MODE_1:
         begin
            events = out_of_range;
         end
         MCA_MODE_2:
         begin
            events = {temp_high, 3'h0, out_of_range[3:0]};
         end
         MCA_MODE_3:
         begin
            events = {temp_high, 1'b0, out_of_range[5:0]};
         end
         default:
         begin
            events = 8'h00;
         end
      endcase
   end

endmodule // mca_status_map
`default_nettype wire

/* File: verification/mca_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// serial engine side: pointer and data byte per strobe
// ---------------------------------------------------------------
module mca_host_model
(
   // clock
   input  wire logic       ref_clk,
   // register port
   output logic            reg_wr,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      // stale data would hide a missing strobe check
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      @(posedge ref_clk);
      @(negedge ref_clk);
      d = reg_rdata;
   endtask
endmodule // mca_host_model
`default_nettype wire

/* File: verification/mca_regs_props.sv */
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// port checks
// ---------------------------------------------------------------
module mca_regs_props
   import mca_pkg::*;
(
   // clock, reset, register port
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // controls and pin
   input wire logic       run,
   input wire logic       scan_hold,
   input wire logic       restore_pulse,
   input wire logic [1:0] mode,
   input wire logic       alarm_n
);
   logic       rst_ok;
   logic [7:0] cfg_seen;

   // the first edge after release still finds the flops in reset
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_ok <= 1'b0;
      else
         rst_ok <= 1'b1;
   end

   // host view of config; only bits 1 and 7 are read from it
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         cfg_seen <= MCA_RST_CONFIG;
      else if (restore_pulse)
         cfg_seen <= MCA_RST_CONFIG;
      else if (reg_wr && reg_addr == MCA_OFS_CONFIG)
         cfg_seen <= reg_wdata & MCA_CFG_WMASK;
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n || !rst_ok);
   // a write in the restore cycle loses, so it is left out
   sequence cfg_wr;
      reg_wr && reg_addr == MCA_OFS_CONFIG && !restore_pulse;
   endsequence
   sequence restore_done;
      restore_pulse ##1 (!restore_pulse && !run && scan_hold && mode == 2'h0);
   endsequence
   property p_ctrl_follow;
      cfg_wr |=> {run, scan_hold} == {$past(reg_wdata[MCA_CFG_START]), $past(reg_wdata[MCA_CFG_CLEAR])};
   endproperty
   property p_restore_seq;
      cfg_wr ##0 reg_wdata[MCA_CFG_INIT] |=> restore_done;
   endproperty
   property p_mode_follow;
      reg_wr && reg_addr == MCA_OFS_ADVCFG && !restore_pulse |=> mode == $past(reg_wdata[MCA_ADV_MODE_LO +: 2]);
   endproperty
   property p_ctrl_hold;
      !(reg_wr && reg_addr == MCA_OFS_CONFIG) && !restore_pulse |=> $stable(run) && $stable(scan_hold);
   endproperty
   property p_cfg_read;
      reg_addr == MCA_OFS_CONFIG
         |=> reg_rdata == {$past(cfg_seen[7]), 3'h0, $past(scan_hold), 1'b0, $past(cfg_seen[1]), $past(run)};
   endproperty
   property p_status_sticky;
      (reg_addr == MCA_OFS_STATUS && !restore_pulse) [*2] |=> (reg_rdata & $past(reg_rdata)) == $past(reg_rdata);
   endproperty
   property p_status_rsvd;
      reg_addr == MCA_OFS_STATUS && mode == 2'h2 |=> reg_rdata[6:4] == 3'h0;
   endproperty
   chk_ctrl_follow: assert property (p_ctrl_follow)
      else $error("control bits wrong");
   chk_restore_seq: assert property (p_restore_seq)
      else $error("restore wrong");
   chk_mode_follow: assert property (p_mode_follow)
      else $error("mode wrong");
   chk_ctrl_hold: assert property (p_ctrl_hold)
      else $error("control moved");
   chk_cfg_read: assert property (p_cfg_read)
      else $error("config read wrong");
   chk_alarm_clear: assert property (scan_hold |=> alarm_n)
      else $error("alarm while cleared");
   chk_status_sticky: assert property (p_status_sticky)
      else $error("status bit fell");
   chk_status_rsvd: assert property (p_status_rsvd)
      else $error("reserved status set");
endmodule // mca_regs_props
bind mca_regs mca_regs_props u_props (.ref_clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .run,
   .scan_hold, .restore_pulse, .mode, .alarm_n);
`default_nettype wire

/* File: verification/monitor_config_and_alarm_status_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module monitor_config_and_alarm_status_tb_top
   import mca_pkg::*;
   ;
   typedef struct packed {logic [1:0] m; logic [7:0] oh; logic [7:0] ul; logic th; logic [7:0] st;} mca_row_t;
   // ---------------------------------------------------------------
   // status mapping cases
   // ---------------------------------------------------------------
   localparam mca_row_t ROWS [6] = '{'{2'h0, 8'h01, 8'h40, 1'b0, 8'h41}, '{2'h0, 8'h00, 8'h80, 1'b0, 8'h00},
      '{2'h1, 8'h80, 8'h01, 1'b1, 8'h81}, '{2'h2, 8'hF0, 8'h03, 1'b1, 8'h83},
      '{2'h3, 8'hC4, 8'h10, 1'b0, 8'h14}, '{2'h3, 8'h00, 8'h00, 1'b1, 8'h80}};
   logic       ref_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       temp_high = 1'b0;
   logic       flags_valid = 1'b0;
   logic [7:0] over_high = 8'h00;
   logic [7:0] under_low = 8'h00;
   logic       reg_wr, run, scan_hold, restore_pulse, alarm_n;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
   logic [1:0] mode;
   wire  [7:0] pins = {2'h0, mode, run, scan_hold, restore_pulse, alarm_n};
   int         n_mismatch = 0;
   int         comparisons = 0;
   int         cycles = 0;
   always #50 ref_clk = ~ref_clk;
   mca_regs dut (.ref_clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .over_high, .under_low,
      .temp_high, .flags_valid, .run, .scan_hold, .restore_pulse, .mode, .alarm_n);
   mca_host_model host (.ref_clk, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata);
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic flag(input logic [7:0] oh, input logic [7:0] ul, input logic th);
      @(posedge ref_clk);
      {over_high, under_low, temp_high, flags_valid} <= {oh, ul, th, 1'b1};
      @(posedge ref_clk);
      // inverted flags outside the strobe must not count
      {over_high, under_low, temp_high, flags_valid} <= {~oh, ~ul, ~th, 1'b0};
   endtask
   task automatic test_done();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_mismatch++;
         test_done();
      end
   end
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      foreach (ROWS[i])
      begin
         host.wr(MCA_OFS_CONFIG, 8'h80);
         host.wr(MCA_OFS_ADVCFG, {5'h00, ROWS[i].m, 1'b0});
         host.wr(MCA_OFS_CONFIG, 8'h01);
         flag(ROWS[i].oh, ROWS[i].ul, ROWS[i].th);
         host.rd(MCA_OFS_STATUS, got);
         check("status", got, ROWS[i].st);
      end
      host.wr(MCA_OFS_STATUS, 8'h00);
      host.wr(MCA_OFS_CONFIG, 8'h03);
      host.rd(MCA_OFS_STATUS, got);
      check("status", got, 8'h80);
      check("pins", pins, 8'h38);
      host.wr(MCA_OFS_MASK, 8'h80);
      host.rd(MCA_OFS_MASK, got);
      check("mask", got, 8'h80);
      check("pins", pins, 8'h39);
      host.wr(MCA_OFS_MASK, 8'h00);
      host.wr(MCA_OFS_CONFIG, 8'h01);
      host.rd(MCA_OFS_CONFIG, got);
      check("config", got, 8'h01);
      check("pins", pins, 8'h39);
      host.wr(MCA_OFS_CONFIG, 8'h7F);
      host.rd(MCA_OFS_CONFIG, got);
      check("config", got, 8'h0B);
      check("pins", pins, 8'h3D);
      host.rd(MCA_OFS_STATUS, got);
      check("status", got, 8'h80);
      host.wr(MCA_OFS_CONFIG, 8'h00);
      flag(8'h01, 8'h00, 1'b0);
      host.rd(MCA_OFS_STATUS, got);
      check("status", got, 8'h80);
      host.wr(MCA_OFS_MASK, 8'hFF);
      host.wr(MCA_OFS_CONFIG, 8'h80);
      @(negedge ref_clk);
      check("pins", pins, 8'h33);
      host.rd(MCA_OFS_CONFIG, got);
      check("config", got, 8'h08);
      host.rd(MCA_OFS_MASK, got);
      check("mask", got, 8'h00);
      check("pins", pins, 8'h05);
      host.wr(MCA_OFS_ADVCFG, 8'hFF);
      host.rd(MCA_OFS_ADVCFG, got);
      check("advcfg", got, 8'h07);
      check("pins", pins, 8'h35);
      host.wr(MCA_OFS_CONFIG, 8'h01);
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check("pins", pins, 8'h05);
      rst_n <= 1'b1;
      host.rd(MCA_OFS_CONFIG, got);
      check("config", got, 8'h08);
      test_done();
   end
endmodule // monitor_config_and_alarm_status_tb_top
`default_nettype wire
